// ---- rtl/spb_top.sv ----
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module spb_top (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Register port
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   // External baud timer overflow, same clock domain
   input  wire logic       timer_ovf_i,
   // Pins
   input  wire logic       data_pin_i,
   output logic            data_pin_o,
   output logic            data_pin_oe_o,
   output logic            shift_clk_o,
   // Baud ticks for the asynchronous framer
   output logic            tx_baud_tick_o,
   output logic            rx_baud_tick_o,
   output logic            irq_o
);
   import spb_pkg::*;

   // ==========================================
   // Registers
   logic [7:0] serial_control_reg;
   logic [7:0] rate_control_reg;
   logic [7:0] power_control_reg;
   logic [7:0] reload_r;
   logic [7:0] serial_buffer;
   logic [7:0] shift_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic [3:0] bit_r;
   spb_state_e state_r;
   logic       is_rx_r;
   logic       data_in;
   logic       gen_ovf;
   logic       div6;
   logic       wr_ctrl;
   logic       wr_buf;
   spb_mode_e  mode;
   logic       mode_sel_hi;
   logic       mode_sel_lo;
   logic       baud_double_bit;
   logic       prescale_bypass_bit;
   logic       rate_gen_run_bit;
   logic       shift_mode_rate_src;
   logic       rx_rate_src;
   logic       tx_rate_src;
   logic       tx_set;
   logic       rx_set;
   logic       m0_tick;
   logic       rx_start;
   logic       tx_half_r;
   logic       rx_half_r;
   logic       gen_tick;
   logic       tim_tick;

   assign mode_sel_hi         = serial_control_reg[CTRL_MODE_HI];
   assign mode_sel_lo         = serial_control_reg[CTRL_MODE_LO];
   assign mode                = spb_mode_e'({mode_sel_hi, mode_sel_lo});
   assign baud_double_bit     = power_control_reg[POWER_DOUBLE];
   assign prescale_bypass_bit = rate_control_reg[RATE_BYPASS];
   assign rate_gen_run_bit    = rate_control_reg[RATE_RUN];
   assign shift_mode_rate_src = rate_control_reg[RATE_M0_SRC];
   assign rx_rate_src         = rate_control_reg[RATE_RX_SRC];
   assign tx_rate_src         = rate_control_reg[RATE_TX_SRC];
   assign wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
   assign wr_buf  = wr_i && (addr_i == ADDR_BUF);

   // ==========================================
   // Baud sources
   spb_div u_div (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .run_i    (rate_gen_run_bit),
      .bypass_i (prescale_bypass_bit),
      .reload_i (reload_r),
      .div6_o   (div6),
      .ovf_o    (gen_ovf)
   );

   spb_sync u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pin_i (data_pin_i),
      .lvl_o (data_in)
   );

   // Without doubling every second overflow counts; doubling uses every one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_half_r <= 1'b0;
         rx_half_r <= 1'b0;
      end else begin
         if (gen_ovf) begin
            tx_half_r <= ~tx_half_r;
         end
         if (timer_ovf_i) begin
            rx_half_r <= ~rx_half_r;
         end
      end
   end
   assign gen_tick = gen_ovf && (baud_double_bit || tx_half_r);
   assign tim_tick = timer_ovf_i && (baud_double_bit || rx_half_r);

   // Timer source is only honoured in the variable-rate UART modes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_baud_tick_o <= 1'b0;
         rx_baud_tick_o <= 1'b0;
      end else if (mode == MODE_U8V || mode == MODE_U9V) begin
         tx_baud_tick_o <= tx_rate_src ? gen_tick : tim_tick;
         rx_baud_tick_o <= rx_rate_src ? gen_tick : tim_tick;
      end else begin
         tx_baud_tick_o <= 1'b0;
         rx_baud_tick_o <= 1'b0;
      end
   end

   assign m0_tick = shift_mode_rate_src ? gen_tick : div6;

   // ==========================================
   // Mode 0 shift engine
   // Mode bits come from the written value, so one write may also leave a UART mode
   assign rx_start = wr_ctrl && !wdata_i[CTRL_MODE_HI] && !wdata_i[CTRL_MODE_LO]
                     && wdata_i[CTRL_RX_EN] && !wdata_i[CTRL_RX_DONE];
   assign tx_set = (state_r == ST_LOW) && m0_tick && (bit_r == BITS_LAST) && !is_rx_r;
   assign rx_set = (state_r == ST_LOW) && m0_tick && (bit_r == BITS_LAST) && is_rx_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r       <= ST_IDLE;
         bit_r         <= 4'h0;
         is_rx_r       <= 1'b0;
         shift_r       <= ZERO8;
         shift_clk_o   <= 1'b1;
         data_pin_o    <= 1'b1;
         data_pin_oe_o <= 1'b0;
         serial_buffer <= ZERO8;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               shift_clk_o <= 1'b1;
               if (mode == MODE_SHIFT && wr_buf) begin
                  state_r       <= ST_HIGH;
                  is_rx_r       <= 1'b0;
                  bit_r         <= 4'h0;
                  shift_r       <= wdata_i;
                  data_pin_o    <= wdata_i[0];
                  data_pin_oe_o <= 1'b1;
               end else if (rx_start) begin
                  state_r       <= ST_HIGH;
                  is_rx_r       <= 1'b1;
                  bit_r         <= 4'h0;
                  data_pin_oe_o <= 1'b0;
               end
            end
            ST_HIGH: begin
               if (m0_tick) begin
                  state_r     <= ST_LOW;
                  shift_clk_o <= 1'b0;
               end
            end
            ST_LOW: begin
               if (m0_tick) begin
                  shift_clk_o <= 1'b1;
                  if (is_rx_r) begin
                     shift_r <= {data_in, shift_r[7:1]};
                  end
                  if (bit_r == BITS_LAST) begin
                     state_r <= ST_IDLE;
                     if (is_rx_r) begin
                        serial_buffer <= {data_in, shift_r[7:1]};
                     end else begin
                        data_pin_o <= 1'b1;
                     end
                  end else begin
                     state_r <= ST_HIGH;
                     bit_r   <= bit_r + 4'h1;
                     if (!is_rx_r) begin
                        shift_r    <= {1'b1, shift_r[7:1]};
                        data_pin_o <= shift_r[1];
                     end
                  end
               end
            end
         endcase
         // A write while a byte is on the wire is dropped, so a capture is never lost
         if (wr_buf && state_r == ST_IDLE) begin
            serial_buffer <= wdata_i;
         end
      end
   end

   // ==========================================
   // Software registers; hardware flag set wins over software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_control_reg <= CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            serial_control_reg <= wdata_i;
         end
         if (tx_set) begin
            serial_control_reg[CTRL_TX_DONE] <= 1'b1;
         end
         if (rx_set) begin
            serial_control_reg[CTRL_RX_DONE] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rate_control_reg  <= RATE_RST;
         power_control_reg <= POWER_RST;
         reload_r          <= RELOAD_RST;
         irq_mask_r        <= 2'b00;
      end else if (wr_i) begin
         if (addr_i == ADDR_RATE) begin
            rate_control_reg <= wdata_i;
         end
         if (addr_i == ADDR_POWER) begin
            power_control_reg <= wdata_i;
         end
         if (addr_i == ADDR_RELOAD) begin
            reload_r <= wdata_i;
         end
         if (addr_i == ADDR_IRQ_MASK) begin
            irq_mask_r <= wdata_i[1:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_r <= 2'b00;
         irq_o      <= 1'b0;
      end else begin
         irq_stat_r[1] <= tx_set || (irq_stat_r[1] &&
                          !(wr_i && addr_i == ADDR_IRQ_STAT && wdata_i[1]));
         irq_stat_r[0] <= rx_set || (irq_stat_r[0] &&
                          !(wr_i && addr_i == ADDR_IRQ_STAT && wdata_i[0]));
         irq_o <= |(irq_stat_r & irq_mask_r);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= ZERO8;
      end else if (rd_i) begin
         unique case (addr_i)
            ADDR_CTRL:     rdata_o <= serial_control_reg;
            ADDR_BUF:      rdata_o <= serial_buffer;
            ADDR_RATE:     rdata_o <= rate_control_reg;
            ADDR_RELOAD:   rdata_o <= reload_r;
            ADDR_POWER:    rdata_o <= power_control_reg;
            ADDR_IRQ_STAT: rdata_o <= {6'h00, irq_stat_r};
            ADDR_IRQ_MASK: rdata_o <= {6'h00, irq_mask_r};
            ADDR_STATUS:   rdata_o <= {5'h00, state_r};
            default:       rdata_o <= ZERO8;
         endcase
      end else begin
         rdata_o <= ZERO8;
      end
   end

   // ==========================================
   // Checks
   a_tx_done_set: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_set |=> serial_control_reg[CTRL_TX_DONE] && data_pin_o)
      else $error("transmit end did not set flag and idle data high");
   a_rx_done_set: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_set |=> serial_control_reg[CTRL_RX_DONE])
      else $error("receive end did not set flag");
   a_tx_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && mode == MODE_SHIFT && wr_buf)
      |=> state_r == ST_HIGH && data_pin_o == $past(wdata_i[0]) && data_pin_oe_o)
      else $error("buffer write did not start shift transmit");
   a_lsb_first: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_LOW && m0_tick && !is_rx_r && bit_r != BITS_LAST)
      |=> data_pin_o == $past(shift_r[1]))
      else $error("next bit not taken from low end");
   a_clk_phase: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == ST_LOW |-> !shift_clk_o)
      else $error("shift clock not low in low phase");
   a_idle_clock: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && $past(state_r) == ST_IDLE) |-> shift_clk_o)
      else $error("shift clock moved while idle");
   a_gen_halt: assert property (@(posedge clk_i) disable iff (rst_i)
      !rate_gen_run_bit ##1 !rate_gen_run_bit |-> !gen_ovf)
      else $error("generator overflowed while halted");
   a_timer_mode: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode == MODE_SHIFT || mode == MODE_U9F) |=> !tx_baud_tick_o && !rx_baud_tick_o)
      else $error("uart tick in a mode without variable rate");
   a_m0_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
      (!shift_mode_rate_src && state_r == ST_HIGH && !div6) |=> state_r == ST_HIGH)
      else $error("fixed shift rate advanced off divide by six");

   // ==========================================
   // Transfer, idle and source checks
   a_rx_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && rx_start) |=> state_r == ST_HIGH && is_rx_r && !data_pin_oe_o)
      else $error("receive start did not release data pin");
   a_rx_capture: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_set |=> serial_buffer == {$past(data_in), $past(shift_r[7:1])})
      else $error("received byte not placed in buffer");
   a_end_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      (tx_set || rx_set) |=> state_r == ST_IDLE && shift_clk_o)
      else $error("transfer end did not return to idle");
   a_bit_range: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r != ST_IDLE |-> bit_r <= BITS_LAST)
      else $error("bit counter past eighth bit");
   a_idle_shift: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && !wr_buf) |=> $stable(shift_r))
      else $error("shift register moved while idle");
   a_idle_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && !wr_ctrl) |=> $stable(serial_control_reg[CTRL_TX_DONE])
      && $stable(serial_control_reg[CTRL_RX_DONE]))
      else $error("done flag changed while idle");
   a_high_clock: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == ST_HIGH |-> shift_clk_o)
      else $error("shift clock not high in high phase");
   a_buf_locked: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_buf && state_r != ST_IDLE && !rx_set) |=> $stable(serial_buffer))
      else $error("buffer written during transfer");
   a_tx_src: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode == MODE_U8V || mode == MODE_U9V)
      |=> tx_baud_tick_o == $past(tx_rate_src ? gen_tick : tim_tick))
      else $error("transmit tick from wrong source");
   a_rx_src: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode == MODE_U8V || mode == MODE_U9V)
      |=> rx_baud_tick_o == $past(rx_rate_src ? gen_tick : tim_tick))
      else $error("receive tick from wrong source");
   a_m0_gen: assert property (@(posedge clk_i) disable iff (rst_i)
      (shift_mode_rate_src && state_r == ST_HIGH && !gen_tick) |=> state_r == ST_HIGH)
      else $error("variable shift rate advanced off generator");
   a_tx_status: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_set |=> irq_stat_r[1])
      else $error("transmit end did not set status bit");
   a_rx_status: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_set |=> irq_stat_r[0])
      else $error("receive end did not set status bit");
endmodule : spb_top
`default_nettype wire

// ---- rtl/spb_pkg.sv ----
package spb_pkg;
   localparam logic [3:0] ADDR_CTRL     = 4'h0;
   localparam logic [3:0] ADDR_BUF      = 4'h1;
   localparam logic [3:0] ADDR_RATE     = 4'h2;
   localparam logic [3:0] ADDR_RELOAD   = 4'h3;
   localparam logic [3:0] ADDR_POWER    = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
   localparam logic [3:0] ADDR_STATUS   = 4'h7;
   // Control register fields
   localparam int CTRL_MODE_HI = 7;
   localparam int CTRL_MODE_LO = 6;
   localparam int CTRL_RX_EN   = 4;
   localparam int CTRL_TX_DONE = 1;
   localparam int CTRL_RX_DONE = 0;
   // Rate control fields
   localparam int RATE_RUN    = 4;
   localparam int RATE_TX_SRC = 3;
   localparam int RATE_RX_SRC = 2;
   localparam int RATE_BYPASS = 1;
   localparam int RATE_M0_SRC = 0;
   localparam int POWER_DOUBLE = 7;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] RATE_RST   = 8'h00;
   localparam logic [7:0] RELOAD_RST = 8'h00;
   localparam logic [7:0] POWER_RST  = 8'h00;
   localparam logic [7:0] ZERO8      = 8'h00;
   localparam logic [7:0] ONES8      = 8'hFF;
   localparam logic [2:0] PRE_DIV_LAST = 3'h5;
   localparam logic [3:0] BITS_LAST    = 4'h7;
   typedef enum logic [1:0] {
      MODE_SHIFT = 2'b00,
      MODE_U8V   = 2'b01,
      MODE_U9F   = 2'b10,
      MODE_U9V   = 2'b11
   } spb_mode_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_HIGH = 3'b010,
      ST_LOW  = 3'b100
   } spb_state_e;
endpackage : spb_pkg

// ---- rtl/spb_div.sv ----
`timescale 1ns/100ps
`default_nettype none
// Divide-by-6 enable and auto-reload overflow counter
module spb_div (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic       bypass_i,
   input  wire logic [7:0] reload_i,
   output logic            div6_o,
   output logic            ovf_o
);
   import spb_pkg::*;
   logic [2:0] pre_r;
   logic [7:0] cnt_r;
   logic       step;

   always_ff @(posedge clk_i) begin
      if (rst_i || pre_r == PRE_DIV_LAST) begin
         pre_r <= 3'h0;
      end else begin
         pre_r <= pre_r + 3'h1;
      end
   end
   assign div6_o = (pre_r == PRE_DIV_LAST);

   assign step = run_i && (bypass_i || div6_o);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= ZERO8;
         ovf_o <= 1'b0;
      end else begin
         ovf_o <= step && (cnt_r == ONES8);
         if (step) begin
            cnt_r <= (cnt_r == ONES8) ? reload_i : cnt_r + 8'h01;
         end
      end
   end
endmodule : spb_div
`default_nettype wire

// ---- rtl/spb_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// Three-stage pin synchroniser; a change counts once stages two and three agree
module spb_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   output logic      lvl_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r  <= 1'b1;
         s2_r  <= 1'b1;
         s3_r  <= 1'b1;
         lvl_o <= 1'b1;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            lvl_o <= s3_r;
         end
      end
   end
endmodule : spb_sync
`default_nettype wire

// ---- tb/spb_shift_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// =========================================
// External shift register on the far side
module spb_shift_model (
   input  wire logic       shift_clk_i,
   input  wire logic       data_i,
   input  wire logic       drive_en_i,
   input  wire logic       arm_i,
   input  wire logic [7:0] rx_byte_i,
   output logic            data_o,
   output logic [7:0]      tx_byte_o,
   output logic [3:0]      tx_bits_o
);
   int idx = 8;
   initial begin
      tx_byte_o = 8'h00;
      tx_bits_o = 4'h0;
   end
   always @(posedge arm_i) begin
      idx = 0;
      tx_bits_o = 4'h0;
   end
   // Capture in the low phase, where the device holds the bit stable
   always @(negedge shift_clk_i) if (drive_en_i) begin
      tx_byte_o = {data_i, tx_byte_o[7:1]};
      tx_bits_o = tx_bits_o + 4'h1;
   end
   // Next bit goes out on the rising clock, after the device sampled it
   always @(posedge shift_clk_i) if (!drive_en_i && idx < 8) idx++;
   // Past the byte the line shows the inverse of its last bit, never a stale copy
   assign data_o = (idx < 8) ? rx_byte_i[idx[2:0]] : ~rx_byte_i[7];
endmodule : spb_shift_model
`default_nettype wire

// ---- tb/spb_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_port_shift_mode_baud_tb_top;
   import spb_pkg::*;
   logic       clk_i, rst_i, wr_i, rd_i, timer_ovf_i, data_pin_i, arm, model_pin;
   logic       data_pin_o, data_pin_oe_o, shift_clk_o, tx_baud_tick_o, rx_baud_tick_o, irq_o;
   logic [3:0] addr_i, tx_bits;
   logic [7:0] wdata_i, rdata_o, v, rx_byte, tx_byte;
   int         error_cnt, samples_checked, cyc, txt, rxt, lo_len, lo_last, m;

   spb_top dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .timer_ovf_i(timer_ovf_i), .data_pin_i(data_pin_i),
      .data_pin_o(data_pin_o), .data_pin_oe_o(data_pin_oe_o), .shift_clk_o(shift_clk_o),
      .tx_baud_tick_o(tx_baud_tick_o), .rx_baud_tick_o(rx_baud_tick_o), .irq_o(irq_o));
   spb_shift_model partner (.shift_clk_i(shift_clk_o), .data_i(data_pin_o),
      .drive_en_i(data_pin_oe_o), .arm_i(arm), .rx_byte_i(rx_byte), .data_o(model_pin),
      .tx_byte_o(tx_byte), .tx_bits_o(tx_bits));
   // Wire level: the device wins while it drives
   assign data_pin_i = data_pin_oe_o ? data_pin_o : model_pin;

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // =========================================
   // Monitors and run limit
   always @(posedge clk_i) begin
      cyc++;
      if (tx_baud_tick_o === 1'b1) txt++;
      if (rx_baud_tick_o === 1'b1) rxt++;
      if (shift_clk_o === 1'b0) lo_len++;
      else if (lo_len != 0) begin
         lo_last = lo_len;
         lo_len = 0;
      end
      if (cyc > 60000) begin
         error_cnt++;
         final_report();
      end
   end

   // =========================================
   // Access tasks
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask : rd
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("BAD %s expected %h got %h", n, e, g);
         error_cnt++;
      end
   endtask : chk
   // Free-running counts land within one tick of the ideal figure
   task automatic near(input string n, input int e, input int g);
      samples_checked++;
      if (g < e - ((e == 0) ? 0 : 1) || g > e + ((e == 0) ? 0 : 1)) begin
         $display("BAD %s expected %0d got %0d", n, e, g);
         error_cnt++;
      end
   endtask : near
   task automatic clr();
      @(posedge clk_i);
      #1 txt = 0;
      rxt = 0;
   endtask : clr
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk_i) timer_ovf_i <= 1'b1;
         @(posedge clk_i) timer_ovf_i <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
   endtask : pulse
   task automatic gen(input logic [7:0] r, input logic [7:0] p, input int n, input int et,
                      input int er);
      wr(ADDR_RATE, r);
      wr(ADDR_POWER, p);
      clr();
      repeat (n) @(posedge clk_i);
      near("gen tx ticks", et, txt);
      near("gen rx ticks", er, rxt);
   endtask : gen
   task automatic wait_flag(input int b);
      int i;
      for (i = 0; i < 200; i++) begin
         rd(ADDR_CTRL, v);
         if (v[b] === 1'b1) break;
      end
      if (i == 200) begin
         $display("BAD done flag expected 1 got 0");
         error_cnt++;
      end
   endtask : wait_flag
   task automatic arm_model();
      #1 arm = 1'b1;
      #1 arm = 1'b0;
   endtask : arm_model
   task automatic final_report();
      $display("Counts: mismatches %0d, comparisons %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report

   // =========================================
   // Scenarios
   initial begin
      rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      timer_ovf_i = 1'b0;
      arm = 1'b0;
      rx_byte = 8'h3C;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      wr(4'h9, 8'hFF);
      for (m = 0; m < 10; m++) begin
         rd(m[3:0], v);
         chk("reset read", (m == 7) ? 8'h01 : 8'h00, v);
      end
      chk("idle clock pin", 8'h01, {7'h00, shift_clk_o});
      // Timer source: only the two variable-rate UART modes use it
      wr(ADDR_RATE, 8'h00);
      for (m = 0; m < 4; m++) begin
         wr(ADDR_CTRL, {m[1:0], 6'h00});
         wr(ADDR_POWER, 8'h00);
         clr();
         pulse(8);
         chk("timer tx ticks", (m[0] == 1'b1) ? 8'h04 : 8'h00, txt[7:0]);
         chk("timer rx ticks", (m[0] == 1'b1) ? 8'h04 : 8'h00, rxt[7:0]);
         wr(ADDR_POWER, 8'h80);
         clr();
         pulse(8);
         chk("doubled timer ticks", (m[0] == 1'b1) ? 8'h08 : 8'h00, txt[7:0]);
      end
      wr(ADDR_RELOAD, 8'hFC);
      // Counter starts from zero, so let it reach the reload loop before counting
      wr(ADDR_RATE, 8'h12);
      repeat (270) @(posedge clk_i);
      wr(ADDR_CTRL, 8'h40);
      gen(8'h16, 8'h00, 400, 0, 50);
      gen(8'h16, 8'h80, 400, 0, 100);
      gen(8'h14, 8'h00, 480, 0, 10);
      gen(8'h06, 8'h00, 400, 0, 0);
      gen(8'h1A, 8'h00, 400, 50, 0);
      // Shift mode transmit at the fixed rate; a second write mid-byte is dropped
      wr(ADDR_RATE, 8'h00);
      wr(ADDR_POWER, 8'h00);
      wr(ADDR_CTRL, 8'h00);
      arm_model();
      wr(ADDR_BUF, 8'hA5);
      wr(ADDR_BUF, 8'h5A);
      wait_flag(CTRL_TX_DONE);
      chk("tx byte", 8'hA5, tx_byte);
      chk("tx clocks", 8'h08, {4'h0, tx_bits});
      chk("fixed low phase", 8'h06, lo_last[7:0]);
      chk("data pin after tx", 8'h01, {7'h00, data_pin_o});
      rd(ADDR_BUF, v);
      chk("buffer after tx", 8'hA5, v);
      rd(ADDR_CTRL, v);
      chk("ctrl after tx", 8'h02, v);
      chk("masked irq", 8'h00, {7'h00, irq_o});
      wr(ADDR_IRQ_MASK, 8'h02);
      repeat (2) @(posedge clk_i);
      chk("raised irq", 8'h01, {7'h00, irq_o});
      wr(ADDR_IRQ_STAT, 8'h02);
      repeat (2) @(posedge clk_i);
      chk("cleared irq", 8'h00, {7'h00, irq_o});
      wr(ADDR_CTRL, 8'h00);
      repeat (50) @(posedge clk_i);
      rd(ADDR_CTRL, v);
      chk("flags stay clear", 8'h00, v);
      // Shift mode at the generator rate, doubled and unscaled
      wr(ADDR_RATE, 8'h13);
      wr(ADDR_POWER, 8'h80);
      arm_model();
      wr(ADDR_BUF, 8'hC3);
      wait_flag(CTRL_TX_DONE);
      chk("gen tx byte", 8'hC3, tx_byte);
      chk("gen low phase", 8'h04, lo_last[7:0]);
      // Shift mode receive
      wr(ADDR_RATE, 8'h00);
      wr(ADDR_POWER, 8'h00);
      arm_model();
      wr(ADDR_CTRL, 8'h10);
      repeat (3) @(posedge clk_i);
      chk("rx drive off", 8'h00, {7'h00, data_pin_oe_o});
      wait_flag(CTRL_RX_DONE);
      rd(ADDR_BUF, v);
      chk("rx byte", 8'h3C, v);
      rd(ADDR_CTRL, v);
      chk("ctrl after rx", 8'h11, v);
      final_report();
   end
endmodule : serial_port_shift_mode_baud_tb_top
`default_nettype wire
